// file: verilog/srr_pkg.sv
// status readback register bank: shared offsets, field positions and counts
// assumes 8-bit register data and addresses decoded on the plain register port
package srr_pkg;

	// register offsets
	localparam logic [7:0] SRR_A_CHIP      = 8'h40;
	localparam logic [7:0] SRR_A_PIN       = 8'h41;
	localparam logic [7:0] SRR_A_RATIO     = 8'h42;
	localparam logic [7:0] SRR_A_RATIO_TOP = 8'h45;
	localparam logic [7:0] SRR_A_CS        = 8'h46;
	localparam logic [7:0] SRR_A_CS_TOP    = 8'h5D;
	localparam logic [7:0] SRR_A_IRQ_STS   = 8'h5E;
	localparam logic [7:0] SRR_A_IRQ_MSK   = 8'h5F;

	// chip status field positions
	localparam int SRR_LOCK_BIT  = 0;
	localparam int SRR_MUTE_BIT  = 1;
	localparam int SRR_ID_LSB    = 2;
	localparam int SRR_ID_W      = 3;
	localparam int SRR_REV_BIT   = 5;

	// channel status and ratio sizes
	localparam int SRR_CS_BITS   = 192;
	localparam int SRR_CS_BYTES  = 24;
	localparam int SRR_RATIO_W   = 32;

	// interrupt status layout
	localparam int SRR_IRQ_W     = 3;
	localparam int SRR_IRQ_LOCK  = 0;
	localparam int SRR_IRQ_MUTE  = 1;
	localparam int SRR_IRQ_CS    = 2;

	// values after reset
	localparam logic [2:0]  SRR_RST_MASK  = 3'h0;
	localparam logic [7:0]  SRR_RST_BYTE  = 8'h00;
	localparam logic [31:0] SRR_RST_RATIO = 32'h0000_0000;

	// divider step count
	localparam logic [5:0]  SRR_DIV_STEPS = 6'h20;

endpackage

// file: verilog/srr_ratio_div.sv
// serial divider producing 2^32 / period, one quotient bit per enabled cycle
// assumes a start pulse only while not busy; period is in core clock cycles
`timescale 1ns/1ps
module srr_ratio_div
	import srr_pkg::*;
#(
	parameter int CW = 32
) (
	// clock and reset
	input  wire logic          core_clk,
	input  wire logic          rst_b,
	input  wire logic          ce,
	// request
	input  wire logic          start,
	input  wire logic [CW-1:0] period,
	// answer
	output logic               busy,
	output logic               done,
	output logic [31:0]        quotient
);

	typedef enum logic {SRR_DIV_IDLE, SRR_DIV_RUN} srr_div_st_t;

	srr_div_st_t      st_q;
	logic [CW:0]      rem_q;
	logic [CW-1:0]    per_q;
	logic [31:0]      quo_q;
	logic [5:0]       cnt_q;
	logic             done_q;
	logic             sat_q;

	// one restoring step on the shifted remainder
	wire logic [CW:0] shifted = {rem_q[CW-1:0], 1'b0};
	wire logic        fits    = shifted >= {1'b0, per_q};
	wire logic [CW:0] rem_n   = fits ? shifted - {1'b0, per_q} : shifted;
	wire logic        tiny    = period < CW'(2);

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q   <= SRR_DIV_IDLE;
			rem_q  <= '0;
			per_q  <= '0;
			quo_q  <= SRR_RST_RATIO;
			cnt_q  <= '0;
			done_q <= 1'b0;
			sat_q  <= 1'b0;
		end else if (ce) begin
			done_q <= 1'b0;
			unique case (st_q)
				SRR_DIV_IDLE: begin
					if (start) begin
						st_q  <= SRR_DIV_RUN;
						rem_q <= (CW+1)'(1);
						per_q <= period;
						sat_q <= tiny;
						cnt_q <= SRR_DIV_STEPS;
					end
				end
				SRR_DIV_RUN: begin
					rem_q <= rem_n;
					quo_q <= sat_q ? 32'hFFFF_FFFF : {quo_q[30:0], fits};
					cnt_q <= cnt_q - 6'h01;
					if (cnt_q == 6'h01) begin
						st_q   <= SRR_DIV_IDLE;
						done_q <= 1'b1;
					end
				end
			endcase
		end
	end

	assign busy     = st_q == SRR_DIV_RUN;
	assign done     = done_q;
	assign quotient = quo_q;

	// quotient is the floor of 2^32 over the period
	chk_ratio_quotient: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(done_q && per_q >= CW'(2)) |->
			(64'(quo_q) * 64'(per_q) <= 64'h1_0000_0000) &&
			((64'(quo_q) + 64'h1) * 64'(per_q) > 64'h1_0000_0000))
		else $error("ratio quotient is not 2^32 over the period");

endmodule

// file: verilog/srr_status_regs.sv
// read-only status register bank with lock, automute, pin level, rate ratio
// and received channel status, plus a sticky interrupt status and mask
// assumes all inputs synchronous to core_clk, which is the master clock
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps

// How it works
// - chip status bit 0 reads one while the clock recovery loop is locked
// - chip status bit 1 reads one while the automute condition is active
// - chip status is read-only: id in bits 4-2, revision bit 5, 7-6 zero
// - 32-bit rate ratio over four bytes, lowest address least significant
// - reading the ratio low byte captures all 32 bits; read low to high
// - ratio equals sample rate over master clock times two to the 32
// - 192 channel status bits over 24 bytes, lowest address least significant
module srr_status_regs
	import srr_pkg::*;
#(
	parameter logic [2:0] DEV_ID   = 3'h1,  // arbitrary identity value
	parameter logic       REV_FLAG = 1'b0,  // arbitrary identity value
	parameter int         PER_W    = 32
) (
	// clock, reset, enable
	input  wire logic                   core_clk,
	input  wire logic                   rst_b,
	input  wire logic                   ce,
	// register port
	input  wire logic [7:0]             reg_addr,
	input  wire logic [7:0]             reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic      [7:0]             reg_rdata,
	// status sources
	input  wire logic                   lock_in,
	input  wire logic                   automute_in,
	input  wire logic                   general_pin_one,
	input  wire logic                   sample_tick,
	input  wire logic [SRR_CS_BITS-1:0] cs_bits,
	input  wire logic                   cs_valid,
	// interrupt
	output logic                        irq
);

	// byte select within a wide vector
	function automatic logic [7:0] cs_byte(input logic [SRR_CS_BITS-1:0] v,
		input logic [7:0] idx);
		cs_byte = v[8*idx +: 8];
	endfunction

	function automatic logic [7:0] ratio_byte(input logic [31:0] v,
		input logic [7:0] idx);
		ratio_byte = v[8*idx[1:0] +: 8];
	endfunction

	logic                   lock_q;
	logic                   mute_q;
	logic                   pin_q;
	logic [PER_W-1:0]       per_cnt_q;
	logic [31:0]            ratio_q;
	logic [31:0]            snap_q;
	logic [SRR_CS_BITS-1:0] cs_q;
	logic [SRR_IRQ_W-1:0]   sts_q;
	logic [SRR_IRQ_W-1:0]   sts_d;
	logic [SRR_IRQ_W-1:0]   mask_q;
	logic [SRR_IRQ_W-1:0]   mask_d;
	logic [7:0]             rdata_q;
	logic [7:0]             rdata_d;
	logic                   irq_q;
	logic                   div_busy;
	logic                   div_done;
	logic [31:0]            div_quo;

	// access decode
	wire logic       rd_en      = reg_rd && ce;
	wire logic       wr_en      = reg_wr && ce;
	wire logic       hit_chip   = reg_addr == SRR_A_CHIP;
	wire logic       hit_pin    = reg_addr == SRR_A_PIN;
	wire logic       hit_ratio  = reg_addr >= SRR_A_RATIO && reg_addr <= SRR_A_RATIO_TOP;
	wire logic       hit_cs     = reg_addr >= SRR_A_CS && reg_addr <= SRR_A_CS_TOP;
	wire logic       hit_sts    = reg_addr == SRR_A_IRQ_STS;
	wire logic       hit_msk    = reg_addr == SRR_A_IRQ_MSK;
	wire logic [7:0] ratio_idx  = reg_addr - SRR_A_RATIO;
	wire logic [7:0] cs_idx     = reg_addr - SRR_A_CS;
	wire logic       lsb_read   = rd_en && reg_addr == SRR_A_RATIO;

	// chip status word
	wire logic [7:0] chip_word  = {2'b00, REV_FLAG, DEV_ID, mute_q, lock_q};
	wire logic [7:0] pin_word   = {7'h00, pin_q};

	// low byte comes live while the snapshot is taken, the rest from the snapshot
	wire logic [7:0] ratio_word = (reg_addr == SRR_A_RATIO) ? ratio_q[7:0]
		: ratio_byte(snap_q, ratio_idx);
	wire logic [7:0] cs_word    = cs_byte(cs_q, cs_idx);

	// events
	wire logic       ev_lock    = lock_q != lock_in;
	wire logic       ev_mute    = mute_q != automute_in;
	wire logic       ev_cs      = cs_valid && cs_bits != cs_q;
	wire logic [2:0] ev_vec     = {ev_cs, ev_mute, ev_lock};

	// period measurement
	wire logic       div_start  = sample_tick && !div_busy;
	wire logic       per_full   = &per_cnt_q;

	always_comb begin
		rdata_d = SRR_RST_BYTE;
		if (hit_chip)
			rdata_d = chip_word;
		else if (hit_pin)
			rdata_d = pin_word;
		else if (hit_ratio)
			rdata_d = ratio_word;
		else if (hit_cs)
			rdata_d = cs_word;
		else if (hit_sts)
			rdata_d = {5'h00, sts_q};
		else if (hit_msk)
			rdata_d = {5'h00, mask_q};
	end

	// set wins over the read clear
	always_comb begin
		sts_d = sts_q;
		if (rd_en && hit_sts)
			sts_d = '0;
		sts_d = sts_d | ev_vec;
	end

	always_comb begin
		mask_d = mask_q;
		if (wr_en && hit_msk)
			mask_d = reg_wdata[SRR_IRQ_W-1:0];
	end

	srr_ratio_div #(
		.CW (PER_W)
	) u_div (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.ce       (ce),
		.start    (div_start),
		.period   (per_cnt_q),
		.busy     (div_busy),
		.done     (div_done),
		.quotient (div_quo)
	);

	// sampled status levels
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			lock_q <= 1'b0;
			mute_q <= 1'b0;
			pin_q  <= 1'b0;
		end else if (ce) begin
			lock_q <= lock_in;
			mute_q <= automute_in;
			pin_q  <= general_pin_one;
		end
	end

	// cycles per sample, then ratio of rates
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			per_cnt_q <= '0;
			ratio_q   <= SRR_RST_RATIO;
		end else if (ce) begin
			if (sample_tick)
				per_cnt_q <= PER_W'(1);
			else if (!per_full)
				per_cnt_q <= per_cnt_q + PER_W'(1);
			if (div_done)
				ratio_q <= div_quo;
		end
	end

	// coherent snapshot taken by the low byte read
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			snap_q <= SRR_RST_RATIO;
		else if (lsb_read)
			snap_q <= ratio_q;
	end

	// received channel status block
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			cs_q <= '0;
		else if (ce && cs_valid)
			cs_q <= cs_bits;
	end

	// interrupt and read data
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sts_q   <= '0;
			mask_q  <= SRR_RST_MASK;
			irq_q   <= 1'b0;
			rdata_q <= SRR_RST_BYTE;
		end else if (ce) begin
			sts_q   <= sts_d;
			mask_q  <= mask_d;
			irq_q   <= |(sts_d & mask_d);
			if (rd_en)
				rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign irq       = irq_q;

	// checks
	sequence s_chip_read;
		rd_en && hit_chip;
	endsequence

	sequence s_lsb_read;
		rd_en && reg_addr == SRR_A_RATIO;
	endsequence

	sequence s_msb_read;
		rd_en && reg_addr == SRR_A_RATIO_TOP;
	endsequence

	chk_lock_bit_read: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		s_chip_read |=> reg_rdata[SRR_LOCK_BIT] == $past(lock_q))
		else $error("lock bit does not follow the loop lock");

	chk_mute_bit_read: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(ce && automute_in) ##1 s_chip_read |=> reg_rdata[SRR_MUTE_BIT])
		else $error("automute bit low while the condition is active");

	chk_chip_fixed_fields: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		s_chip_read |=> reg_rdata[7:SRR_ID_LSB] == {2'b00, REV_FLAG, DEV_ID})
		else $error("fixed chip status fields are wrong");

	chk_ratio_msb_byte: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		s_msb_read |=> reg_rdata == $past(snap_q[31:24]))
		else $error("ratio top byte is not the most significant");

	chk_ratio_snapshot: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		s_lsb_read |=> snap_q == $past(ratio_q) && reg_rdata == snap_q[7:0])
		else $error("low byte read did not capture the ratio");

	chk_ratio_coherent: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		s_lsb_read ##1 (!lsb_read)[*3] |-> snap_q == $past(snap_q, 2))
		else $error("ratio snapshot changed without a low byte read");

	chk_ratio_from_div: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(ce && div_done) |=> ratio_q == $past(div_quo))
		else $error("ratio did not take the divider result");

	chk_cs_byte_read: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(rd_en && hit_cs) |=> reg_rdata == cs_byte($past(cs_q), $past(cs_idx)))
		else $error("channel status byte read back wrong");

	chk_pin_level_read: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(rd_en && hit_pin) |=> reg_rdata == {7'h00, $past(pin_q)})
		else $error("pin status does not show the pin level");

	chk_irq_level: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		irq == |(sts_q & mask_q))
		else $error("interrupt level disagrees with masked status");

	chk_mute_low_read: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(ce && !automute_in) ##1 s_chip_read |=> !reg_rdata[SRR_MUTE_BIT])
		else $error("automute bit high while the condition is inactive");

	chk_ratio_low_live: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		s_lsb_read |=> reg_rdata == $past(ratio_q[7:0]))
		else $error("ratio low byte is not the live value");

	chk_sts_set_wins: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(ce && ev_lock) |=> sts_q[SRR_IRQ_LOCK])
		else $error("lock change did not set its status bit");

	chk_sts_read_clear: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(rd_en && hit_sts && ev_vec == 3'h0) |=> sts_q == '0)
		else $error("status read did not clear the status bits");

	chk_mask_write: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(wr_en && hit_msk) |=> mask_q == $past(reg_wdata[SRR_IRQ_W-1:0]))
		else $error("mask write did not land");

	chk_unmapped_read: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(rd_en && !(hit_chip || hit_pin || hit_ratio || hit_cs || hit_sts || hit_msk))
			|=> reg_rdata == SRR_RST_BYTE)
		else $error("unmapped read did not return zero");

	chk_ce_freeze: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		!ce |=> $stable(reg_rdata) && $stable(irq))
		else $error("outputs moved while the clock enable was low");

endmodule

// file: test/testbench.sv
// self-checking bench for the status readback register bank
// assumes the bank answers reads one cycle later and core_clk is the master clock
`timescale 1ns/1ps
module testbench
	import srr_pkg::*;
;
	localparam logic [2:0] ID_V  = 3'h5;  // arbitrary identity value
	localparam logic       REV_V = 1'b1;  // arbitrary identity value
	typedef struct {string nm; logic [7:0] val;} srr_note_t;

	logic                   core_clk, rst_b, ce;
	logic [7:0]             reg_addr, reg_wdata, reg_rdata;
	logic                   reg_wr, reg_rd, irq, rd_seen;
	logic                   lock_in, automute_in, general_pin_one, sample_tick, cs_valid;
	logic [SRR_CS_BITS-1:0] cs_bits, cs;
	logic [63:0]            r_old, r_new;
	logic [2:0]             sts;
	logic                   pl, pm, pp;
	logic [3:0]             fs_code [5] = '{4'h0, 4'h2, 4'h3, 4'hA, 4'hE};
	int                     fi;
	integer                 seed = 32'hcc8b5897;
	int                     mismatches = 0;
	int                     compares = 0;
	srr_note_t              notes[$];
	srr_note_t              n;

	srr_status_regs #(.DEV_ID(ID_V), .REV_FLAG(REV_V), .PER_W(32)) DUT (
		.core_clk(core_clk), .rst_b(rst_b), .ce(ce),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .lock_in(lock_in), .automute_in(automute_in),
		.general_pin_one(general_pin_one), .sample_tick(sample_tick),
		.cs_bits(cs_bits), .cs_valid(cs_valid), .irq(irq));

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		notes.push_back('{nm, e});
		@(posedge core_clk);
		reg_rd   <= 1'b0;
	endtask

	task automatic wait_irq(input logic e);
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		check("irq", {7'h00, irq}, {7'h00, e});
	endtask

	task automatic run_ticks(input int p);
		for (int t = 0; t < 5; t++) begin
			@(posedge core_clk);
			sample_tick <= 1'b1;
			@(posedge core_clk);
			sample_tick <= 1'b0;
			repeat (p - 2) @(posedge core_clk);
		end
		repeat (40) @(posedge core_clk);
	endtask

	// read monitor: oldest note against the answer of each taken read
	always @(posedge core_clk) rd_seen <= reg_rd & ce & rst_b;
	always @(negedge core_clk) begin
		if (rd_seen) begin
			if (notes.size() == 0) begin
				mismatches++;
				$display("wrong value read note expected queued seen none");
			end else begin
				n = notes.pop_front();
				check(n.nm, reg_rdata, n.val);
			end
		end
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		mismatches++;
		finish_test();
	end

	initial begin
		rst_b = 1'b0; ce = 1'b1; reg_addr = 8'h00; reg_wdata = 8'h00;
		reg_wr = 1'b0; reg_rd = 1'b0; lock_in = 1'b0; automute_in = 1'b0;
		general_pin_one = 1'b0; sample_tick = 1'b0; cs_valid = 1'b0; cs_bits = '0;
		repeat (4) @(posedge core_clk);
		rst_b <= 1'b1;
		// reset values and unmapped places
		rd(SRR_A_CHIP, {2'b00, REV_V, ID_V, 2'b00}, "chip status");
		rd(SRR_A_PIN, 8'h00, "pin status");
		rd(SRR_A_IRQ_MSK, 8'h00, "irq mask");
		rd(SRR_A_IRQ_STS, 8'h00, "irq status");
		rd(8'h00, 8'h00, "unmapped low");
		rd(8'h60, 8'h00, "unmapped high");
		wait_irq(1'b0);
		$display("test reset values done");
		// lock, automute and pin levels, chip status stays read-only
		pl = 1'b0; pm = 1'b0; sts = 3'h0;
		for (int i = 0; i < 4; i++) begin
			pp = 1'($random(seed));
			@(posedge core_clk);
			lock_in <= i[0]; automute_in <= i[1]; general_pin_one <= pp;
			repeat (3) @(posedge core_clk);
			sts = sts | {1'b0, pm ^ i[1], pl ^ i[0]};
			pl = i[0];
			pm = i[1];
			wr(SRR_A_CHIP, 8'hFF);
			rd(SRR_A_CHIP, {2'b00, REV_V, ID_V, pm, pl}, "chip status");
			rd(SRR_A_PIN, {7'h00, pp}, "pin status");
		end
		rd(SRR_A_IRQ_STS, {5'h00, sts}, "irq status");
		rd(SRR_A_IRQ_STS, 8'h00, "irq status cleared");
		$display("test status levels done");
		// interrupt mask, raise and clear; a mask write ignored while disabled
		@(posedge core_clk);
		ce <= 1'b0;
		wr(SRR_A_IRQ_MSK, 8'h07);
		@(posedge core_clk);
		ce <= 1'b1;
		rd(SRR_A_IRQ_MSK, 8'h00, "irq mask frozen");
		wr(SRR_A_IRQ_MSK, 8'h01);
		rd(SRR_A_IRQ_MSK, 8'h01, "irq mask");
		@(posedge core_clk);
		lock_in <= 1'b0;
		wait_irq(1'b1);
		rd(SRR_A_IRQ_STS, 8'h01, "irq status lock");
		wait_irq(1'b0);
		@(posedge core_clk);
		automute_in <= 1'b0;
		wait_irq(1'b0);
		rd(SRR_A_IRQ_STS, 8'h02, "irq status mute");
		$display("test interrupts done");
		// channel status blocks with both format flag values
		wr(SRR_A_IRQ_MSK, 8'h04);
		for (int b = 0; b < 2; b++) begin
			for (int k = 0; k < 6; k++) cs[32*k +: 32] = $random(seed);
			fi = $unsigned($random(seed)) % 5;
			cs[27:24] = fs_code[fi];
			cs[0] = b[0];
			for (int s = 0; s < 2; s++) begin
				@(posedge core_clk);
				cs_bits <= cs; cs_valid <= 1'b1;
				@(posedge core_clk);
				cs_valid <= 1'b0;
				wait_irq(s == 0);
				rd(SRR_A_IRQ_STS, (s == 0) ? 8'h04 : 8'h00, "irq status block");
			end
			for (int k = 0; k < 24; k++)
				rd(SRR_A_CS + 8'(k), cs[8*k +: 8], "channel status");
			rd(SRR_A_CS, {cs[7:1], b[0]}, "format flag");
			rd(SRR_A_CS + 8'h03, {cs[31:28], fs_code[fi]}, "rate nibble");
		end
		$display("test channel status done");
		// rate ratio capture on the low byte
		run_ticks(37);
		r_old = 64'h1_0000_0000 / 37;
		for (int k = 0; k < 4; k++)
			rd(SRR_A_RATIO + 8'(k), r_old[8*k +: 8], "ratio");
		run_ticks(200);
		r_new = 64'h1_0000_0000 / 200;
		rd(SRR_A_RATIO_TOP, r_old[31:24], "ratio snapshot");
		rd(SRR_A_RATIO + 8'h01, r_old[15:8], "ratio snapshot");
		for (int k = 0; k < 4; k++)
			rd(SRR_A_RATIO + 8'(k), r_new[8*k +: 8], "ratio");
		$display("test rate ratio done");
		// reset in mid-run returns ratio and mask to their reset values
		@(posedge core_clk);
		rst_b <= 1'b0;
		repeat (4) @(posedge core_clk);
		rst_b <= 1'b1;
		rd(SRR_A_RATIO, SRR_RST_RATIO[7:0], "ratio after reset");
		rd(SRR_A_RATIO_TOP, SRR_RST_RATIO[31:24], "ratio top after reset");
		rd(SRR_A_IRQ_MSK, {5'h00, SRR_RST_MASK}, "irq mask after reset");
		$display("test mid-run reset done");
		repeat (4) @(posedge core_clk);
		if (notes.size() != 0) begin
			mismatches++;
			$display("wrong value read notes expected 0 seen %0d", notes.size());
		end
		finish_test();
	end
endmodule
